// file: shared/chsm_defines.svh
/*
 * Register offsets, bit positions and reset values of the card host status and interrupt mask bank.
 * Assumes a 32-bit classic Wishbone slave port with byte addresses.
 */
`ifndef CHSM_DEFINES_SVH
`define CHSM_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CHSM_OFF_EVENT_STATUS 8'h00
`define CHSM_OFF_LEVEL_STATUS 8'h04
`define CHSM_OFF_IRQ_MASK 8'h08

// ****************************************************************
// event status / mask bit positions
// ****************************************************************
`define CHSM_EV_W 13
`define CHSM_EV_DATA_COMPLETE 0
`define CHSM_EV_BUSY_RELEASE 1
`define CHSM_EV_CMD_RESPONSE 2
`define CHSM_EV_READ_TIMEOUT 3
`define CHSM_EV_RESP_TIMEOUT 4
`define CHSM_EV_WRITE_CRC 5
`define CHSM_EV_READ_CRC 6
`define CHSM_EV_RESP_CRC 7
`define CHSM_EV_DAT3_EDGE 11
`define CHSM_EV_LAST_BYTE 12
`define CHSM_MASK_WRITABLE 13'h1eff
`define CHSM_EV_RESET 13'h0000

// ****************************************************************
// level status bit positions
// ****************************************************************
`define CHSM_LV_W 7
`define CHSM_LV_BUSY 0
`define CHSM_LV_CLOCK_STOPPED 1
`define CHSM_LV_TX_EMPTY 2
`define CHSM_LV_RX_FULL 3
`define CHSM_LV_DAT3 4
`define CHSM_LV_FIFO_EMPTY 5
`define CHSM_LV_FIFO_FULL 6

`endif

// file: shared/chsm_pkg.sv
/*
 * Types of the card host status and interrupt mask bank.
 * Assumes chsm_defines.svh is on the include path.
 */
`include "chsm_defines.svh"

package chsm_pkg;

  // busy tracker after a command that expects busy
  typedef enum logic [1:0] {
    BT_IDLE,
    BT_WAIT,
    BT_BUSY
  } chsm_busy_t;

  typedef struct packed {
    logic [`CHSM_EV_W-1:0] ev;
    logic [`CHSM_EV_W-1:0] mask;
    logic [`CHSM_LV_W-1:0] lvl;
    logic ack;
    logic [31:0] rdat;
    logic irq;
    logic dat3_prev;
    chsm_busy_t bt;
    logic pend;
    logic crc_ok;
    logic hold;
  } chsm_state_t;

endpackage

// file: design/chsm_status.sv
/*
 * Status registers and interrupt enable mask of a memory card host controller, with a classic
 * Wishbone slave, busy tracking, data completion sequencing and a masked rising-edge interrupt.
 * Assumes all inputs are synchronous to clk_i and event inputs are one-cycle pulses.
 */
// Decided for this implementation: the register offsets and register access over Wishbone.
// How it works
// [R1] write crc error pulse sets event bit 5
// [R2] response wait expiry sets event bit 4
// [R3] read data wait expiry sets event bit 3
// [R4] command sent without response, or response received, sets event bit 2
// [R5] busy end, or expected busy never seen, sets event bit 1
// [R6] event bit 0 set only when block data fully moved
// [R7] commands accepted at any time, also during a block transfer
// [R8] mid-transfer busy-expecting command holds data path until busy released
// [R9] last byte of transfer sets event bit 12 at once
// [R10] event bit 0 waits for crc check and programming after bit 12
// [R11] level status register never raises an interrupt
// [R12] level bit 4 follows the dat3 line
// [R13] level bit 3 shows receive data register full
// [R14] level bit 2 shows transmit register and shift register both empty
// [R15] level bit 1 set while card clock held low for any reason
// [R16] level bit 0 set while card busy is detected
// [R17] mask bit 1 enables, 0 disables, matching event interrupt
// [R18] enabled event flag rising from 0 to 1 pulses the interrupt
// [R19] reading the event register clears its flags
// [R20] reserved bits read zero and ignore writes; mask bits 9 and 10 are writable here and read back what was written
`timescale 1ns/10ps
`default_nettype none
`include "chsm_defines.svh"

module chsm_status #(
  parameter int ADR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // events from command and data engines
  input wire logic write_crc_error_i,
  input wire logic read_crc_error_i,
  input wire logic response_crc_error_i,
  input wire logic response_timeout_i,
  input wire logic read_data_timeout_i,
  input wire logic cmd_response_done_i,
  input wire logic cmd_issue_i,
  input wire logic busy_expected_i,
  input wire logic busy_window_end_i,
  input wire logic xfer_active_i,
  input wire logic last_byte_done_i,
  input wire logic crc_check_done_i,
  // card and datapath levels
  input wire logic busy_detect_i,
  input wire logic dat3_level_i,
  input wire logic fifo_full_flag_i,
  input wire logic fifo_empty_flag_i,
  input wire logic rx_register_full_i,
  input wire logic tx_data_empty_i,
  input wire logic tx_shift_empty_i,
  input wire logic rx_shift_full_i,
  input wire logic card_clock_on_i,
  // outputs
  output logic data_hold_o,
  output logic irq_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  chsm_pkg::chsm_state_t s_q;
  chsm_pkg::chsm_state_t s_d;

  logic req;
  logic [`CHSM_EV_W-1:0] ev_set;
  logic [`CHSM_EV_W-1:0] ev_clr;
  logic [`CHSM_EV_W-1:0] ev_rise;
  logic [7:0] adr;

  assign adr = wb_adr_i[7:0];
  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    ev_set = '0;
    ev_clr = '0;

    // event sources
    ev_set[`CHSM_EV_WRITE_CRC] = write_crc_error_i; // R1
    ev_set[`CHSM_EV_RESP_TIMEOUT] = response_timeout_i; // R2
    ev_set[`CHSM_EV_READ_TIMEOUT] = read_data_timeout_i; // R3
    ev_set[`CHSM_EV_CMD_RESPONSE] = cmd_response_done_i; // R4
    ev_set[`CHSM_EV_READ_CRC] = read_crc_error_i;
    ev_set[`CHSM_EV_RESP_CRC] = response_crc_error_i;
    ev_set[`CHSM_EV_DAT3_EDGE] = dat3_level_i ^ s_q.dat3_prev;
    ev_set[`CHSM_EV_LAST_BYTE] = last_byte_done_i; // R9
    s_d.dat3_prev = dat3_level_i;

    // busy tracker; commands never wait for the data path
    case (s_q.bt)
      chsm_pkg::BT_IDLE: begin
        if (cmd_issue_i && busy_expected_i) begin // R7
          s_d.bt = chsm_pkg::BT_WAIT;
        end
      end
      chsm_pkg::BT_WAIT: begin
        if (busy_detect_i) begin
          s_d.bt = chsm_pkg::BT_BUSY;
        end else if (busy_window_end_i) begin
          ev_set[`CHSM_EV_BUSY_RELEASE] = 1'b1; // R5
          s_d.bt = chsm_pkg::BT_IDLE;
        end
      end
      chsm_pkg::BT_BUSY: begin
        if (!busy_detect_i) begin
          ev_set[`CHSM_EV_BUSY_RELEASE] = 1'b1; // R5
          s_d.bt = chsm_pkg::BT_IDLE;
        end
      end
      default: begin
        s_d.bt = chsm_pkg::BT_IDLE;
      end
    endcase

    // data path hold for a busy-expecting command during a transfer
    if (cmd_issue_i && xfer_active_i && busy_expected_i) begin
      s_d.hold = 1'b1; // R8
    end else if (ev_set[`CHSM_EV_BUSY_RELEASE]) begin
      s_d.hold = 1'b0; // R8
    end

    // data completion follows last byte, crc check and programming
    if (last_byte_done_i) begin
      s_d.pend = 1'b1; // R10
      s_d.crc_ok = crc_check_done_i;
    end else if (s_q.pend && crc_check_done_i) begin
      s_d.crc_ok = 1'b1;
    end
    if (s_q.pend && s_q.crc_ok && !busy_detect_i) begin
      ev_set[`CHSM_EV_DATA_COMPLETE] = 1'b1; // R6 R10
      s_d.pend = 1'b0;
      s_d.crc_ok = 1'b0;
    end

    // bus access: answer one cycle after the request
    s_d.ack = req;
    s_d.rdat = '0; // R20
    if (req) begin
      if (adr == `CHSM_OFF_EVENT_STATUS) begin
        s_d.rdat[`CHSM_EV_W-1:0] = s_q.ev;
        if (!wb_we_i) begin
          ev_clr = s_q.ev; // R19
        end
      end else if (adr == `CHSM_OFF_LEVEL_STATUS) begin
        s_d.rdat[`CHSM_LV_W-1:0] = s_q.lvl;
      end else if (adr == `CHSM_OFF_IRQ_MASK) begin
        s_d.rdat[`CHSM_EV_W-1:0] = s_q.mask;
        if (wb_we_i) begin
          if (wb_sel_i[0]) begin
            s_d.mask[7:0] = wb_dat_i[7:0] & 8'(`CHSM_MASK_WRITABLE); // R17 R20
          end
          if (wb_sel_i[1]) begin
            s_d.mask[`CHSM_EV_W-1:8] = wb_dat_i[`CHSM_EV_W-1:8] & 5'(`CHSM_MASK_WRITABLE >> 8); // R20
          end
        end
      end
    end

    // set wins over read clear
    s_d.ev = (s_q.ev & ~ev_clr) | ev_set;

    // interrupt on enabled 0 to 1 transitions of event flags only
    ev_rise = ev_set & ~s_q.ev; // R18
    s_d.irq = |(ev_rise & s_q.mask); // R11 R17 R18

    // level status, polled only
    s_d.lvl = '0;
    s_d.lvl[`CHSM_LV_BUSY] = busy_detect_i; // R16
    s_d.lvl[`CHSM_LV_CLOCK_STOPPED] = ~card_clock_on_i | rx_shift_full_i | tx_shift_empty_i; // R15
    s_d.lvl[`CHSM_LV_TX_EMPTY] = tx_data_empty_i & tx_shift_empty_i; // R14
    s_d.lvl[`CHSM_LV_RX_FULL] = rx_register_full_i; // R13
    s_d.lvl[`CHSM_LV_DAT3] = dat3_level_i; // R12
    s_d.lvl[`CHSM_LV_FIFO_EMPTY] = fifo_empty_flag_i;
    s_d.lvl[`CHSM_LV_FIFO_FULL] = fifo_full_flag_i;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign irq_o = s_q.irq;
  assign data_hold_o = s_q.hold;

endmodule

`default_nettype wire

// file: sim/chsm_status_props.sv
/* assertions on the ports of the card host status bank
   bound into chsm_status; single clock, synchronous reset */
`timescale 1ns/10ps
`default_nettype none
module chsm_status_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic cmd_issue_i,
  input wire logic busy_expected_i,
  input wire logic xfer_active_i,
  input wire logic data_hold_o,
  input wire logic irq_o
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence answer_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_time_a: assert property (take_s |=> answer_s) else $error("ack not one cycle after request");
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  rsvd_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:13] == 19'h0) else $error("reserved bits set");
  hold_rise_a: assert property (cmd_issue_i && busy_expected_i && xfer_active_i |=> data_hold_o)
    else $error("data path not held");
  hold_keep_a: assert property (cmd_issue_i && !busy_expected_i && !data_hold_o |=> !data_hold_o)
    else $error("data path held without busy");
  reset_quiet_a: assert property ($fell(rst_i) |-> !irq_o && !data_hold_o && !wb_ack_o)
    else $error("outputs active after reset");
endmodule
bind chsm_status chsm_status_props i_chsm_status_props (.*);
`default_nettype wire

// file: sim/chsm_card_model.sv
/* card side model: drives busy after a busy-expecting command
   len_i cycles of busy, 0 means the card never signals busy */
`timescale 1ns/10ps
`default_nettype none
module chsm_card_model (
  input wire logic clk_i,
  input wire logic cmd_i,
  input wire logic bsy_exp_i,
  input wire logic [7:0] len_i,
  output logic busy_o
);
  logic [7:0] left_q = 8'h0;
  always_ff @(posedge clk_i) begin
    if (cmd_i && bsy_exp_i) left_q <= len_i;
    else if (left_q != 8'h0) left_q <= left_q - 8'h1;
  end
  assign busy_o = left_q != 8'h0;
endmodule
`default_nettype wire

// file: sim/test_chsm_status.sv
/* self-checking bench of the card host status bank
   wishbone master, engine pulses and random levels; card model gives busy */
`timescale 1ns/10ps
`default_nettype none
module test_chsm_status;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, bexp = 0, xfer = 0, busy, hold, irq, ack;
  logic [7:0] adr = 0, len = 0, lv = 8'h40;
  logic [3:0] sel = 4'h3;
  logic [9:0] evp = 0;
  logic [31:0] dat = 0, q, rdat;
  logic [15:0] lf = 16'hdb19;
  int err_count = 0, n_compared = 0;
  always #20 clk_i = ~clk_i;
  chsm_status i_chsm_status (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .write_crc_error_i(evp[5]), .read_crc_error_i(evp[6]), .response_crc_error_i(evp[7]),
    .response_timeout_i(evp[4]), .read_data_timeout_i(evp[3]), .cmd_response_done_i(evp[2]),
    .cmd_issue_i(evp[8]), .busy_expected_i(bexp), .busy_window_end_i(evp[9]), .xfer_active_i(xfer),
    .last_byte_done_i(evp[0]), .crc_check_done_i(evp[1]), .busy_detect_i(busy), .dat3_level_i(lv[7]),
    .fifo_full_flag_i(lv[0]), .fifo_empty_flag_i(lv[1]), .rx_register_full_i(lv[2]),
    .tx_data_empty_i(lv[3]), .tx_shift_empty_i(lv[4]), .rx_shift_full_i(lv[5]),
    .card_clock_on_i(lv[6]), .data_hold_o(hold), .irq_o(irq));
  chsm_card_model i_chsm_card_model (.clk_i(clk_i), .cmd_i(evp[8]), .bsy_exp_i(bexp), .len_i(len), .busy_o(busy));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] lvl_exp(input logic [7:0] v, input logic b);
    return {25'h0, v[0], v[1], v[7], v[2], v[3] & v[4], ~v[6] | v[5] | v[4], b};
  endfunction
  task automatic give_verdict();
    $display("compared %0d, wrong %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    adr <= a;
    we <= w;
    dat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        give_verdict();
      end
      @(posedge clk_i);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic pl(input int k);
    evp[k] <= 1'b1;
    @(posedge clk_i);
    evp <= 10'h0;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h08, 32'h0);
    rd(8'h00, 32'h0);
    wb(8'h00, 1'b1, 32'hffff);
    rd(8'h00, 32'h0);
    rd(8'h0c, 32'h0);
    wb(8'h08, 1'b1, 32'hffffffff);
    rd(8'h08, 32'h1eff);
    sel <= 4'h1;
    wb(8'h08, 1'b1, 32'h0);
    rd(8'h08, 32'h1e00);
    sel <= 4'h3;
    for (int k = 2; k < 8; k++) begin
      for (int m = 0; m < 2; m++) begin
        lf = nxt(lf);
        wb(8'h08, 1'b1, m ? 32'h1 << k : {16'h0, lf} & ~(32'h1 << k));
        pl(k);
        @(posedge clk_i);
        chk(irq, m);
        rd(8'h00, 32'h1 << k);
        rd(8'h00, 32'h0);
      end
    end
    xfer <= 1'b1;
    bexp <= 1'b1;
    len <= 8'd20;
    pl(8);
    @(posedge clk_i);
    chk(hold, 1'b1);
    rd(8'h04, lvl_exp(lv, 1'b1));
    repeat (60) if (hold === 1'b1) @(posedge clk_i);
    chk(hold, 1'b0);
    rd(8'h00, 32'h2);
    len <= 8'd0;
    pl(8);
    @(posedge clk_i);
    pl(9);
    @(posedge clk_i);
    rd(8'h00, 32'h2);
    bexp <= 1'b0;
    pl(8);
    @(posedge clk_i);
    chk(hold, 1'b0);
    xfer <= 1'b0;
    pl(0);
    rd(8'h00, 32'h1000);
    pl(1);
    @(posedge clk_i);
    rd(8'h00, 32'h1);
    wb(8'h08, 1'b1, 32'h17ff);
    repeat (8) begin
      lf = nxt(lf);
      lv <= lf[7:0];
      repeat (2) begin
        @(posedge clk_i);
        chk(irq, 1'b0);
      end
      rd(8'h04, lvl_exp(lf[7:0], 1'b0));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
